// *** inc/sba_pkg.sv ***
package sba_pkg;
    // Number of request/grant triples served as arbiter
    localparam int SBA_NUM_MASTERS = 3;
    // Index of the triple shared with own mastership
    localparam int SBA_PRIMARY_IDX = 0;
    // Reset values of the outputs (all signals active high inside the block)
    localparam logic SBA_GRANT_RST = 1'h0;
    localparam logic SBA_REQ_RST = 1'h0;
    // Index value meaning no master currently owns the bus
    localparam logic [1:0] SBA_OWNER_NONE = 2'h3;

    // Arbiter state, Gray coded along idle -> addr -> data only; idle -> data and data -> idle flip both bits
    typedef enum logic [1:0] {
        SBA_IDLE = 2'h0,
        SBA_ADDR = 2'h1,
        SBA_DATA = 2'h3
    } sba_state_type;
endpackage

// *** hw/sba_sync.sv ***
// Two flip-flop synchroniser for pin inputs
module sba_sync import sba_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sba_sync_state_type;

    sba_sync_state_type st_q;
    sba_sync_state_type st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d.meta = din;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.sync;
endmodule

// *** hw/sba_arbiter.sv ***
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - As arbiter, take requests from and grant the bus to up to three masters.
// - Each master has its own request, grant and data grant triple.
// - Per triple, a setting says whether the master is a same-family device.
// - Triples two and three only serve external masters, never own requests.
// - Not arbiter: triple one drives own request, waits for grant and data grant.
module sba_arbiter import sba_pkg::*; #(
    parameter int NUM_MASTERS = SBA_NUM_MASTERS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic arbiter_mode,
    input wire logic [NUM_MASTERS-1:0] same_family_master,
    input wire logic primary_bus_request,
    input wire logic ext_master2_request,
    input wire logic ext_master3_request,
    input wire logic bus_release,
    input wire logic own_bus_request,
    input wire logic primary_bus_grant_in,
    input wire logic primary_data_grant_in,
    output logic primary_bus_grant,
    output logic primary_data_grant,
    output logic primary_bus_request_out,
    output logic primary_bus_request_oe,
    output logic ext_master2_grant,
    output logic ext_master2_data_grant,
    output logic ext_master3_grant,
    output logic ext_master3_data_grant,
    output logic own_bus_owned,
    output logic [1:0] bus_owner
);
    if (NUM_MASTERS != SBA_NUM_MASTERS) begin : g_bad_count
        $error("sba_arbiter supports exactly three request triples");
    end

    typedef struct packed {
        sba_state_type state;
        logic [1:0] owner;
        logic [NUM_MASTERS-1:0] grant;
        logic [NUM_MASTERS-1:0] dgrant;
        logic own_req;
        logic own_owned;
    } sba_arb_state_type;

    sba_arb_state_type st_q;
    sba_arb_state_type st_d;

    logic [NUM_MASTERS-1:0] req_raw;
    logic [NUM_MASTERS-1:0] req_sync;
    logic [1:0] grt_sync;
    logic rel_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Every pin input passes two flops; each master keeps its own line
    assign req_raw = {ext_master3_request, ext_master2_request, primary_bus_request};

    sba_sync #(.WIDTH(NUM_MASTERS)) u_req_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(req_raw),
        .dout(req_sync)
    );

    sba_sync #(.WIDTH(2)) u_grt_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({primary_data_grant_in, primary_bus_grant_in}),
        .dout(grt_sync)
    );

    sba_sync #(.WIDTH(1)) u_rel_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(bus_release),
        .dout(rel_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // Same-family masters get the data grant one cycle after the address grant
    // and release on their own signal; other masters get both at once and
    // release when their request drops. Priority is fixed: triple 1 first.
    always_comb begin
        st_d = st_q;
        st_d.grant = '0;
        st_d.dgrant = '0;
        if (arbiter_mode) begin
            st_d.own_req = SBA_REQ_RST;
            st_d.own_owned = 1'h0;
            case (st_q.state)
                SBA_IDLE: begin
                    st_d.owner = SBA_OWNER_NONE;
                    for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
                        if (req_sync[i]) begin
                            st_d.owner = 2'(i);
                        end
                    end
                    if (st_d.owner != SBA_OWNER_NONE) begin
                        st_d.grant[st_d.owner] = 1'h1;
                        if (same_family_master[st_d.owner]) begin
                            st_d.state = SBA_ADDR;
                        end else begin
                            st_d.dgrant[st_d.owner] = 1'h1;
                            st_d.state = SBA_DATA;
                        end
                    end
                end
                SBA_ADDR: begin
                    st_d.grant[st_q.owner] = 1'h1;
                    st_d.dgrant[st_q.owner] = 1'h1;
                    st_d.state = SBA_DATA;
                end
                SBA_DATA: begin
                    st_d.grant[st_q.owner] = 1'h1;
                    st_d.dgrant[st_q.owner] = 1'h1;
                    if (same_family_master[st_q.owner] ? rel_sync
                                                       : !req_sync[st_q.owner]) begin
                        st_d.grant = '0;
                        st_d.dgrant = '0;
                        st_d.owner = SBA_OWNER_NONE;
                        st_d.state = SBA_IDLE;
                    end
                end
                default: begin
                    st_d.owner = SBA_OWNER_NONE;
                    st_d.state = SBA_IDLE;
                end
            endcase
        end else begin
            // Only the first triple carries the device's own request
            st_d.state = SBA_IDLE;
            st_d.owner = SBA_OWNER_NONE;
            st_d.own_req = own_bus_request;
            st_d.own_owned = own_bus_request && grt_sync[0] && grt_sync[1];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q.state <= SBA_IDLE;
            st_q.owner <= SBA_OWNER_NONE;
            st_q.grant <= '0;
            st_q.dgrant <= '0;
            st_q.own_req <= SBA_REQ_RST;
            st_q.own_owned <= 1'h0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops; triples 2 and 3 carry no own request
    assign primary_bus_grant = st_q.grant[SBA_PRIMARY_IDX];
    assign primary_data_grant = st_q.dgrant[SBA_PRIMARY_IDX];
    assign ext_master2_grant = st_q.grant[1];
    assign ext_master2_data_grant = st_q.dgrant[1];
    assign ext_master3_grant = st_q.grant[2];
    assign ext_master3_data_grant = st_q.dgrant[2];
    assign primary_bus_request_out = st_q.own_req;
    assign primary_bus_request_oe = st_q.own_req; // Drive only while requesting
    assign own_bus_owned = st_q.own_owned;
    assign bus_owner = st_q.owner;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    one_grant_a: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0(st_q.grant) && $onehot0(st_q.dgrant))
        else $error("more than one grant active");

    prio_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        (arbiter_mode && st_q.state == SBA_IDLE && req_sync[0])
        |=> st_q.grant[0])
        else $error("first triple lost priority");

    grant_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st_q.grant[1]) |-> $past(req_sync[1]) && !$past(req_sync[0]))
        else $error("grant without request");

    fam_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(st_q.grant[0]) && same_family_master[0] && arbiter_mode)
        |-> !st_q.dgrant[0] ##1 st_q.dgrant[0])
        else $error("same-family data grant timing wrong");

    nonfam_same_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(st_q.grant[2]) && !same_family_master[2]) |-> st_q.dgrant[2])
        else $error("data grant missing with grant");

    ext_no_own_a: assert property (@(posedge clk) disable iff (sys_rst)
        !arbiter_mode |=> (st_q.grant == '0) && (st_q.dgrant == '0))
        else $error("grant driven while not arbiter");

    own_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
        own_bus_owned |-> $past(grt_sync[0]) && $past(grt_sync[1]))
        else $error("own mastership without grants");

    own_req_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!arbiter_mode && own_bus_request) |=> primary_bus_request_out)
        else $error("own request not driven");

    dedicated_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.grant[1] |-> !st_q.dgrant[0] && !st_q.dgrant[2])
        else $error("data grant on foreign triple");
endmodule

// *** verif/sba_master_model.sv ***
// Far side: three bus masters plus an outside arbiter for own mode
module sba_master_model import sba_pkg::*; (
    input wire logic clk,
    input wire logic [2:0] req_cmd,
    input wire logic release_cmd,
    input wire logic primary_bus_request_out,
    input wire logic primary_bus_request_oe,
    output logic primary_bus_request,
    output logic ext_master2_request,
    output logic ext_master3_request,
    output logic bus_release,
    output logic primary_bus_grant_in,
    output logic primary_data_grant_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gnt_q = 1'h0;
    // Shared pin: the device wins while it drives, masters never fight it
    assign primary_bus_request = primary_bus_request_oe ? primary_bus_request_out
                                                        : req_cmd[0];
    // Each master owns its own request line
    assign ext_master2_request = req_cmd[1];
    assign ext_master3_request = req_cmd[2];
    assign bus_release = release_cmd;
    // Outside arbiter grants at the first falling edge after the device request rises
    always @(negedge clk) begin
        gnt_q <= primary_bus_request_out & primary_bus_request_oe;
    end
    assign primary_bus_grant_in = gnt_q;
    assign primary_data_grant_in = gnt_q;
endmodule

// *** verif/sba_arbiter_tb.sv ***
module sba_arbiter_tb import sba_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, sys_rst = 1'h1, arbiter_mode = 1'h1, release_cmd = 1'h0;
    logic own_bus_request = 1'h0;
    logic [2:0] same_family_master = 3'h0, req_cmd = 3'h0;
    logic r1, r2, r3, brel, gi, dgi, g1, dg1, ro, roe, g2, dg2, g3, dg3, owned;
    logic [1:0] bus_owner;
    int err_total = 0, checks = 0, cycles = 0;
    wire logic [7:0] st = {g1, dg1, g2, dg2, g3, dg3, bus_owner};

    sba_master_model FAR (.clk(clk), .req_cmd(req_cmd), .release_cmd(release_cmd),
        .primary_bus_request_out(ro), .primary_bus_request_oe(roe),
        .primary_bus_request(r1), .ext_master2_request(r2), .ext_master3_request(r3),
        .bus_release(brel), .primary_bus_grant_in(gi), .primary_data_grant_in(dgi));
    sba_arbiter DUT (.clk(clk), .sys_rst(sys_rst), .arbiter_mode(arbiter_mode),
        .same_family_master(same_family_master), .primary_bus_request(r1),
        .ext_master2_request(r2), .ext_master3_request(r3), .bus_release(brel),
        .own_bus_request(own_bus_request), .primary_bus_grant_in(gi),
        .primary_data_grant_in(dgi), .primary_bus_grant(g1), .primary_data_grant(dg1),
        .primary_bus_request_out(ro), .primary_bus_request_oe(roe),
        .ext_master2_grant(g2), .ext_master2_data_grant(dg2), .ext_master3_grant(g3),
        .ext_master3_data_grant(dg3), .own_bus_owned(owned), .bus_owner(bus_owner));

    // Free running clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers: inputs move at falling edges only
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t status %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the next owner, arbitration gap is not fixed here
    task automatic wait_owner();
        for (int i = 0; i < 8 && bus_owner === SBA_OWNER_NONE; i++) cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Plain master: both grants together, dropped with the request
    task automatic plain_master();
        req_cmd = 3'h1;
        cyc(2);
        chk(st, 8'h03);
        cyc(1);
        chk(st, 8'hC0);
        req_cmd = 3'h0;
        cyc(3);
        chk(st, 8'h03);
        cyc(2);
    endtask
    // Same-family master: data grant one cycle late, held until release
    task automatic family_master();
        same_family_master = 3'h2;
        req_cmd = 3'h2;
        cyc(3);
        chk(st, 8'h21);
        cyc(1);
        chk(st, 8'h31);
        req_cmd = 3'h0;
        cyc(4);
        chk(st, 8'h31);
        release_cmd = 1'h1;
        cyc(3);
        chk(st, 8'h03);
        release_cmd = 1'h0;
        same_family_master = 3'h0;
        cyc(2);
    endtask
    // Same-family master on the first triple: late data grant, freed by release and request drop together
    task automatic family_primary();
        same_family_master = 3'h1;
        req_cmd = 3'h1;
        cyc(3);
        chk(st, 8'h80);
        cyc(1);
        chk(st, 8'hC0);
        req_cmd = 3'h0;
        release_cmd = 1'h1;
        cyc(3);
        chk(st, 8'h03);
        release_cmd = 1'h0;
        same_family_master = 3'h0;
        cyc(2);
    endtask
    // All three at once: served one by one in fixed order
    task automatic priority_order();
        req_cmd = 3'h7;
        cyc(3);
        chk(st, 8'hC0);
        req_cmd = 3'h6;
        cyc(3);
        wait_owner();
        chk(st, 8'h31);
        req_cmd = 3'h4;
        cyc(3);
        wait_owner();
        chk(st, 8'h0E);
        req_cmd = 3'h0;
        cyc(5);
        chk(st, 8'h03);
    endtask
    // Not arbiter: first triple asks outward, second triple stays unserved
    task automatic own_mode();
        arbiter_mode = 1'h0;
        req_cmd = 3'h2;
        own_bus_request = 1'h1;
        for (int i = 0; i < 8 && owned !== 1'h1; i++) cyc(1);
        chk({3'h0, ro, roe, owned, g2, dg2}, 8'h1C);
        cyc(4);
        chk({6'h00, g2, dg2}, 8'h00);
        own_bus_request = 1'h0;
        req_cmd = 3'h0;
        cyc(4);
        chk({5'h00, ro, roe, owned}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard, the full run needs well under 200 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        cyc(5);
        sys_rst = 1'h0;
        cyc(1);
        chk(st, 8'h03);
        plain_master();
        family_master();
        family_primary();
        priority_order();
        own_mode();
        finish_test();
    end
endmodule
